// ===== pin_and_memory_config_bank_test.sv
// self-checking bench for the pin and memory configuration bank
`timescale 1ns/1ps
module pin_and_memory_config_bank_test;
    logic sys_clk, rst_b, regWrEn, regRdEn, regHit, memBusy, sclIn, sclOut;
    logic sclOe, memReadMode, memProgMode, memEraseMode, memProtected;
    logic chassisIntrusionClear, refSelHigh, overtempAlertReq;
    logic [7:0] regAddr, regWrData, regRdData, tachPinEnable;
    logic [2:0] memTestBits;
    logic [16:0] generalPinIn, generalPinOut, generalPinOe;
    logic [16:0] generalPinAssertReq, generalPinAsserted;
    int errors = 0;
    int comparisons = 0;
    assign sclIn = sclOe ? sclOut : 1'b1; // bus clock has a pull-up
    pmcb_bank dut (.sys_clk, .rst_b, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .regHit, .tachPinEnable, .memBusy,
        .memReadMode, .memProgMode, .memEraseMode, .memProtected,
        .memTestBits, .sclIn, .sclOut, .sclOe, .chassisIntrusionClear,
        .refSelHigh, .overtempAlertReq, .generalPinIn, .generalPinOut,
        .generalPinOe, .generalPinAssertReq, .generalPinAsserted);
    pmcb_host host (.sys_clk, .regRdData, .regHit, .sclOe, .regWrEn,
        .regRdEn, .regAddr, .regWrData);
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask : chk
    // read back and compare data and acknowledge
    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic h;
        host.rd(addr, d, h);
        chk({9'h000, d}, {9'h000, exp});
        chk({16'h0000, h}, {16'h0000, addr >= 8'h06 && addr <= 8'h0B});
    endtask : rdchk
    // let register and pad stages settle after a write
    task automatic settle;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic wrap_up;
        if (errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #100000;
        errors++;
        wrap_up;
    end
    initial begin
        rst_b = 1'b0;
        tachPinEnable = 8'h00;
        memBusy = 1'b0;
        overtempAlertReq = 1'b0;
        generalPinIn = 17'h00000;
        generalPinAssertReq = 17'h00000;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int a = 6; a <= 12; a++) rdchk(a[7:0], 8'h00);
        tachPinEnable <= 8'hFF;
        overtempAlertReq <= 1'b1;
        generalPinAssertReq <= 17'h1A5A5;
        // groups alternate active-low and active-high outputs
        for (int g = 0; g < 4; g++) begin
            host.wr(8'h08 + g[7:0], g[0] ? 8'hFF : 8'h55);
        end
        for (int g = 0; g < 4; g++) begin
            rdchk(8'h08 + g[7:0], g[0] ? 8'hFF : 8'h55);
        end
        settle;
        chk(generalPinOe, 17'h1FFFF);
        chk(generalPinOut, 17'h0AAAA);
        tachPinEnable <= 8'h00;
        settle;
        chk(generalPinOe, 17'h1FF00);
        host.wr(8'h0A, 8'h02);
        generalPinIn <= 17'h00F00;
        settle;
        chk({13'h0000, generalPinAsserted[11:8]}, 17'h00001);
        host.wr(8'h06, 8'h71);
        settle;
        chk({13'h0000, memTestBits, memReadMode}, 17'h0000F);
        rdchk(8'h06, 8'h71);
        // one mode bit at a time, as software must
        for (int i = 0; i < 3; i++) begin
            host.wr(8'h06, 8'h01 << i);
            settle;
            chk({14'h0000, memEraseMode, memProgMode, memReadMode},
                17'h1 << i);
        end
        host.wr(8'h06, 8'h8E);
        settle;
        chk({14'h0000, memProtected, memEraseMode, memProgMode},
            17'h00004);
        memBusy <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({15'h0000, sclOut, sclOe}, 17'h00001);
        memBusy <= 1'b0;
        host.wr(8'h06, 8'h00);
        rdchk(8'h06, 8'h08);
        host.wr(8'h07, 8'hFF);
        #1;
        chk({16'h0000, chassisIntrusionClear}, 17'h00001);
        rdchk(8'h07, 8'hC5);
        chk({16'h0000, chassisIntrusionClear}, 17'h00000);
        settle;
        chk({14'h0000, generalPinOe[16], generalPinOut[16], refSelHigh},
            17'h00007);
        wrap_up;
    end
endmodule : pin_and_memory_config_bank_test

// ===== pmcb_bank.sv
// pin and memory configuration register bank
`timescale 1ns/1ps
module pmcb_bank (
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port from the serial management bus engine
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regHit,
    // pin enables from configuration register 2, same clock
    input wire logic [7:0] tachPinEnable,
    // memory side
    input wire logic memBusy,
    output logic memReadMode,
    output logic memProgMode,
    output logic memEraseMode,
    output logic memProtected,
    output logic [2:0] memTestBits,
    // serial clock stretch, open drain
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    // chassis intrusion and reference
    output logic chassisIntrusionClear,
    output logic refSelHigh,
    // thermal alert from the limit logic, active high request
    input wire logic overtempAlertReq,
    // general pins 0 to 16, pin 16 shares the alert output
    input wire logic [16:0] generalPinIn,
    output logic [16:0] generalPinOut,
    output logic [16:0] generalPinOe,
    input wire logic [16:0] generalPinAssertReq,
    output logic [16:0] generalPinAsserted
);
    localparam logic [7:0] RST_VAL = pmcb_pkg::BANK_RESET;
    logic readReq_ff;
    logic progReq_ff;
    logic eraseReq_ff;
    logic protect_ff;
    logic [pmcb_pkg::MM_TEST_W-1:0] testBits_ff;
    logic stretchEn_ff;
    logic pin16Sel_ff;
    logic pin16Dir_ff;
    logic pin16Pol_ff;
    logic refSel_ff;
    logic [7:0] memModeRd;
    logic [7:0] thirdCfgRd;
    logic [7:0] grp_ff [pmcb_pkg::NUM_GRP];
    logic intrClr_ff;
    logic [16:0] pinSync;
    logic [16:0] pinDir;
    logic [16:0] pinPol;
    logic [16:0] pinEn;
    logic [16:0] assertReq;
    logic [16:0] asserted;
    logic pin16Sel;
    logic wrMem;
    logic wrThird;
    logic nxt_protect;
    logic [7:0] nxt_rdData;
    logic nxt_hit;

    assign wrMem = regWrEn && (regAddr == pmcb_pkg::MEM_MODE_OFS);
    assign wrThird = regWrEn && (regAddr == pmcb_pkg::THIRD_CFG_OFS);

    // mode requests held as written; software keeps them exclusive
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            readReq_ff <= RST_VAL[pmcb_pkg::MM_READ_BIT];
            progReq_ff <= RST_VAL[pmcb_pkg::MM_PROG_BIT];
            eraseReq_ff <= RST_VAL[pmcb_pkg::MM_ERASE_BIT];
        end else if (wrMem) begin
            readReq_ff <= regWrData[pmcb_pkg::MM_READ_BIT];
            progReq_ff <= regWrData[pmcb_pkg::MM_PROG_BIT];
            eraseReq_ff <= regWrData[pmcb_pkg::MM_ERASE_BIT];
        end
    end

    // protect is write-once: a write may set it, only reset clears it
    assign nxt_protect = protect_ff | regWrData[pmcb_pkg::MM_PROT_BIT];
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            protect_ff <= RST_VAL[pmcb_pkg::MM_PROT_BIT];
        end else if (wrMem) begin
            protect_ff <= nxt_protect;
        end
    end

    // factory test bits are stored but steer nothing in this bank
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            testBits_ff <=
                RST_VAL[pmcb_pkg::MM_TEST_LSB +: pmcb_pkg::MM_TEST_W];
        end else if (wrMem) begin
            testBits_ff <=
                regWrData[pmcb_pkg::MM_TEST_LSB +: pmcb_pkg::MM_TEST_W];
        end
    end

    // stretch enable; the pad is pulled only while memory is busy
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stretchEn_ff <= RST_VAL[pmcb_pkg::MM_STRETCH_BIT];
        end else if (wrMem) begin
            stretchEn_ff <= regWrData[pmcb_pkg::MM_STRETCH_BIT];
        end
    end

    // pin 16 function, direction and polarity; bits 5-3 not stored
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin16Sel_ff <= RST_VAL[pmcb_pkg::TC_PIN16_SEL_BIT];
            pin16Dir_ff <= RST_VAL[pmcb_pkg::TC_PIN16_DIR_BIT];
            pin16Pol_ff <= RST_VAL[pmcb_pkg::TC_PIN16_POL_BIT];
        end else if (wrThird) begin
            pin16Sel_ff <= regWrData[pmcb_pkg::TC_PIN16_SEL_BIT];
            pin16Dir_ff <= regWrData[pmcb_pkg::TC_PIN16_DIR_BIT];
            pin16Pol_ff <= regWrData[pmcb_pkg::TC_PIN16_POL_BIT];
        end
    end

    // reference level select
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            refSel_ff <= RST_VAL[pmcb_pkg::TC_REF_SEL_BIT];
        end else if (wrThird) begin
            refSel_ff <= regWrData[pmcb_pkg::TC_REF_SEL_BIT];
        end
    end

    // memory mode readback image, rebuilt from the field flops
    always_comb begin
        memModeRd = '0;
        memModeRd[pmcb_pkg::MM_READ_BIT] = readReq_ff;
        memModeRd[pmcb_pkg::MM_PROG_BIT] = progReq_ff;
        memModeRd[pmcb_pkg::MM_ERASE_BIT] = eraseReq_ff;
        memModeRd[pmcb_pkg::MM_PROT_BIT] = protect_ff;
        memModeRd[pmcb_pkg::MM_TEST_LSB +: pmcb_pkg::MM_TEST_W] =
            testBits_ff;
        memModeRd[pmcb_pkg::MM_STRETCH_BIT] = stretchEn_ff;
    end
    // third configuration image; bits 5-3 and the clear bit read zero
    always_comb begin
        thirdCfgRd = '0;
        thirdCfgRd[pmcb_pkg::TC_PIN16_SEL_BIT] = pin16Sel_ff;
        thirdCfgRd[pmcb_pkg::TC_REF_SEL_BIT] = refSel_ff;
        thirdCfgRd[pmcb_pkg::TC_PIN16_DIR_BIT] = pin16Dir_ff;
        thirdCfgRd[pmcb_pkg::TC_PIN16_POL_BIT] = pin16Pol_ff;
    end

    // intrusion clear is a one-cycle pulse; the bit reads back as zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            intrClr_ff <= 1'b0;
        end else begin
            intrClr_ff <= wrThird &
                regWrData[pmcb_pkg::TC_INTR_CLR_BIT];
        end
    end

    // four pin groups, one generate loop over the offsets
    for (genvar g = 0; g < pmcb_pkg::NUM_GRP; g++) begin : gGrp
        localparam logic [7:0] OFS = pmcb_pkg::GRP0_OFS + 8'(g);
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                grp_ff[g] <= pmcb_pkg::BANK_RESET;
            end else if (regWrEn && (regAddr == OFS)) begin
                grp_ff[g] <= regWrData;
            end
        end
    end

    // read mux; unmapped offsets answer zero with no hit
    always_comb begin
        nxt_rdData = 8'h00;
        nxt_hit = 1'b1;
        case (regAddr)
            pmcb_pkg::MEM_MODE_OFS: nxt_rdData = memModeRd;
            pmcb_pkg::THIRD_CFG_OFS: nxt_rdData = thirdCfgRd;
            pmcb_pkg::GRP0_OFS: nxt_rdData = grp_ff[0];
            pmcb_pkg::GRP1_OFS: nxt_rdData = grp_ff[1];
            pmcb_pkg::GRP2_OFS: nxt_rdData = grp_ff[2];
            pmcb_pkg::GRP3_OFS: nxt_rdData = grp_ff[3];
            default: nxt_hit = 1'b0;
        endcase
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= RST_VAL;
            regHit <= 1'b0;
        end else begin
            regHit <= (regRdEn | regWrEn) & nxt_hit;
            if (regRdEn) begin
                regRdData <= nxt_rdData;
            end
        end
    end

    // mode outputs; protect overrides program and erase
    assign memReadMode = readReq_ff;
    assign memProtected = protect_ff;
    assign memProgMode = progReq_ff & ~protect_ff;
    assign memEraseMode = eraseReq_ff & ~protect_ff;
    assign memTestBits = testBits_ff;
    // several mode bits at once is left to software to avoid
    assign chassisIntrusionClear = intrClr_ff;
    assign refSelHigh = refSel_ff;

    // clock stretch only while enabled and the memory is busy
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclOe <= 1'b0;
        end else begin
            sclOe <= stretchEn_ff & memBusy;
        end
    end
    assign sclOut = 1'b0;

    // sclIn is not needed inside; the host sees the held line itself
    logic sclUnused;
    assign sclUnused = sclIn;

    // pin configuration fan-out, even bit direction, odd bit polarity
    for (genvar p = 0; p < pmcb_pkg::PIN16_IDX; p++) begin : gCfg
        localparam int G = p / pmcb_pkg::PINS_PER_REG;
        localparam int B = (p % pmcb_pkg::PINS_PER_REG) *
            pmcb_pkg::GRP_BITS_PER_PIN;
        assign pinDir[p] = grp_ff[G][B + pmcb_pkg::GRP_DIR_OFS];
        assign pinPol[p] = grp_ff[G][B + pmcb_pkg::GRP_POL_OFS];
        if (p < pmcb_pkg::NUM_TACH_PINS) begin : gTach
            assign pinEn[p] = tachPinEnable[p];
        end else begin : gFix
            assign pinEn[p] = 1'b1;
        end
        assign assertReq[p] = generalPinAssertReq[p];
    end

    // pin 16 shares its pad with the overtemperature alert
    assign pin16Sel = pin16Sel_ff;
    assign pinDir[pmcb_pkg::PIN16_IDX] = pin16Sel ?
        pin16Dir_ff : 1'b1;
    // alert pad is driven active low when not a general pin
    assign pinPol[pmcb_pkg::PIN16_IDX] = pin16Sel ?
        pin16Pol_ff : 1'b0;
    assign pinEn[pmcb_pkg::PIN16_IDX] = 1'b1;
    assign assertReq[pmcb_pkg::PIN16_IDX] = pin16Sel ?
        generalPinAssertReq[pmcb_pkg::PIN16_IDX] : overtempAlertReq;

    // pads arrive from outside the clock domain
    pmcb_sync2 #(.WIDTH(pmcb_pkg::NUM_PINS)) uSync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .asyncIn(generalPinIn),
        .syncOut(pinSync)
    );

    // one cell per pin
    for (genvar p = 0; p < pmcb_pkg::NUM_PINS; p++) begin : gPin
        pmcb_pin_cell uCell (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .pinEnable(pinEn[p]),
            .dirOut(pinDir[p]),
            .polHigh(pinPol[p]),
            .assertReq(assertReq[p]),
            .padSync(pinSync[p]),
            .padOut(generalPinOut[p]),
            .padOe(generalPinOe[p]),
            .assertedIn(asserted[p])
        );
    end

    // pin 16 input reads zero while it carries the alert
    assign generalPinAsserted = {asserted[pmcb_pkg::PIN16_IDX] & pin16Sel,
        asserted[pmcb_pkg::PIN16_IDX-1:0]};
endmodule : pmcb_bank

// ===== pmcb_bank_checker.sv
// port assertions for the pin and memory configuration bank
`timescale 1ns/1ps
module pmcb_bank_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regHit,
    input wire logic memBusy,
    input wire logic memReadMode,
    input wire logic memProgMode,
    input wire logic memEraseMode,
    input wire logic memProtected,
    input wire logic [2:0] memTestBits,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic chassisIntrusionClear,
    input wire logic refSelHigh
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // clear request and its single-cycle answer
    sequence s_clrWrite;
        regWrEn && regAddr == 8'h07 && regWrData[1];
    endsequence
    sequence s_clrPulse;
        chassisIntrusionClear ##1 !chassisIntrusionClear;
    endsequence
    a_clear_pulse: assert property (s_clrWrite |=> s_clrPulse)
        else $error("intrusion clear pulse wrong");
    a_read_mode: assert property (regWrEn && regAddr == 8'h06 |=>
        memReadMode == $past(regWrData[0]))
        else $error("read mode does not follow write");
    a_test_bits: assert property (regWrEn && regAddr == 8'h06 |=>
        memTestBits == $past(regWrData[6:4]))
        else $error("test bits not stored");
    a_ref_select: assert property (regWrEn && regAddr == 8'h07 |=>
        refSelHigh == $past(regWrData[2]))
        else $error("reference select wrong");
    a_prot_sticky: assert property (memProtected |=> memProtected)
        else $error("protect bit cleared without reset");
    a_prot_blocks: assert property (memProtected |->
        !memProgMode && !memEraseMode)
        else $error("program or erase while protected");
    a_zero_bits: assert property (regRdEn && regAddr == 8'h07 |=>
        regRdData[5:3] == 3'h0)
        else $error("unused bits read nonzero");
    a_stretch_busy: assert property (sclOe |->
        $past(memBusy) && sclOut == 1'b0)
        else $error("clock held low while not busy");
    a_hit_mapped: assert property (regRdEn && regAddr >= 8'h06 &&
        regAddr <= 8'h0B |=> regHit)
        else $error("mapped read not acknowledged");
endmodule : pmcb_bank_checker

bind pmcb_bank pmcb_bank_checker chk_i (.sys_clk, .rst_b, .regWrEn,
    .regRdEn, .regAddr, .regWrData, .regRdData, .regHit, .memBusy,
    .memReadMode, .memProgMode, .memEraseMode, .memProtected, .memTestBits,
    .sclOut, .sclOe, .chassisIntrusionClear, .refSelHigh);

// ===== pmcb_host.sv
// management bus host stand-in that issues register strobes
`timescale 1ns/1ps
module pmcb_host (
    input wire logic sys_clk,
    input wire logic [7:0] regRdData,
    input wire logic regHit,
    input wire logic sclOe,
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // one write; waits while the device holds the bus clock low
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        while (sclOe) @(posedge sys_clk);
        regWrEn <= 1'b1;
        regAddr <= addr;
        regWrData <= data;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        regAddr <= ~addr; // released lines never show a stale value
        regWrData <= ~data;
    endtask : wr
    // one read; data and hit are taken once the answer edge has landed
    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
        output logic hit);
        @(posedge sys_clk);
        regRdEn <= 1'b1;
        regAddr <= addr;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        regAddr <= ~addr;
        #1;
        data = regRdData;
        hit = regHit;
    endtask : rd
endmodule : pmcb_host

// ===== pmcb_pin_cell.sv
// one general pin: direction, polarity and function select
`timescale 1ns/1ps
module pmcb_pin_cell (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic pinEnable,
    input wire logic dirOut,
    input wire logic polHigh,
    input wire logic assertReq,
    input wire logic padSync,
    output logic padOut,
    output logic padOe,
    output logic assertedIn
);
    // driven pad level and enable come from flops to avoid glitches
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            padOut <= 1'b0;
            padOe <= 1'b0;
        end else begin
            padOe <= pinEnable & dirOut;
            padOut <= polHigh ? assertReq : ~assertReq;
        end
    end

    // input seen through the polarity; zero when pin is not a general pin
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            assertedIn <= 1'b0;
        end else begin
            assertedIn <= pinEnable & ~dirOut & (polHigh ? padSync : ~padSync);
        end
    end
endmodule : pmcb_pin_cell

// ===== pmcb_pkg.sv
// shared constants for the pin and memory configuration bank
package pmcb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_PINS = 17;
    localparam int NUM_TACH_PINS = 8;
    localparam int PINS_PER_REG = 4;
    localparam int NUM_GRP = 4;

    // register offsets
    localparam logic [7:0] MEM_MODE_OFS = 8'h06;
    localparam logic [7:0] THIRD_CFG_OFS = 8'h07;
    localparam logic [7:0] GRP0_OFS = 8'h08;
    localparam logic [7:0] GRP1_OFS = 8'h09;
    localparam logic [7:0] GRP2_OFS = 8'h0A;
    localparam logic [7:0] GRP3_OFS = 8'h0B;

    // reset value shared by all six registers
    localparam logic [7:0] BANK_RESET = 8'h00;

    // memory mode control fields
    localparam int MM_READ_BIT = 0;
    localparam int MM_PROG_BIT = 1;
    localparam int MM_ERASE_BIT = 2;
    localparam int MM_PROT_BIT = 3;
    localparam int MM_TEST_LSB = 4;
    localparam int MM_TEST_W = 3;
    localparam int MM_STRETCH_BIT = 7;

    // third configuration fields
    localparam int TC_PIN16_SEL_BIT = 0;
    localparam int TC_INTR_CLR_BIT = 1;
    localparam int TC_REF_SEL_BIT = 2;
    localparam int TC_PIN16_DIR_BIT = 6;
    localparam int TC_PIN16_POL_BIT = 7;
    // bits 5-3 read as zero and drop writes
    localparam logic [7:0] TC_WRITE_MASK = 8'hC7;
    localparam logic [7:0] TC_STORE_MASK = 8'hC5;

    // pin group layout: even bit direction, odd bit polarity
    localparam int GRP_DIR_OFS = 0;
    localparam int GRP_POL_OFS = 1;
    localparam int GRP_BITS_PER_PIN = 2;
    localparam int PIN16_IDX = 16;
endpackage : pmcb_pkg

// ===== pmcb_sync2.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pmcb_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;

    // first stage is read only by the second stage
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            syncOut <= '0;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule : pmcb_sync2
